// [rtl/timer_top.sv]
// 16-bit timer: continuous, dual pwm, capture-restart, comparator
// counter; registers on a plain strobe port, read data a cycle later
// assumes synchronous inputs and one system clock domain
//
// Function
// - continuous mode counts prescaled clock up to reload
// - at reload raise interrupt, restart count at one
// - continuous reload toggles output when alternate enabled
// - pwm polarity zero: match high, reload low
// - pwm polarity one inverts output levels; deadband gaps stay low in both
// - deadband delays only rising edges of outputs
// - capture edge rising at polarity zero, else falling
// - comparator counter: disabled output equals polarity, toggles
// - enabled alternate pin shows polarity while disabled
// - polarity change while running waits for next pwm event, else for stop
// - prescale divides by two to exponent power
`timescale 1ns/100ps
module timer_top
  import timer_pkg::*;
(
  input  wire logic              ref_clk,           // 20 MHz system clock
  input  wire logic              reset_n,           // async reset, active low
  input  wire logic [ADDR_W-1:0] addr,              // register address
  input  wire logic [DATA_W-1:0] wr_data,           // write data
  input  wire logic              wr_strobe,         // one-cycle write
  input  wire logic              rd_strobe,         // one-cycle read
  output logic      [DATA_W-1:0] rd_data,           // read data, next cycle
  input  wire logic              timer_in,          // capture or count input
  output logic                   timer_output_pin,  // timer output level
  output logic                   timer_pin_oe,      // pin driven by timer
  output logic                   timer_output_comp, // complement output
  output logic                   reload_pulse,      // one cycle per reload
  output logic                   irq                // masked status level
);

  ////////////////////////////////////////////////////////////
  // state

  ctrl_t            ctrl_reg,    ctrl_next;
  ctrl_zero_t       ctrl0_reg,   ctrl0_next;
  logic [CNT_W-1:0] count_reg,   count_next;
  logic [CNT_W-1:0] reload_reg,  reload_next;
  logic [CNT_W-1:0] pwm_reg,     pwm_next;
  logic [CNT_W-1:0] capture_reg, capture_next;
  irq_t             status_reg,  status_next;
  irq_t             mask_reg,    mask_next;
  logic             out_reg,     out_next;
  logic             in_prev_reg;
  logic             pulse_reg,   pulse_next;
  logic             irq_reg,     irq_next;
  logic             oe_reg;
  logic [DATA_W-1:0] rd_reg,     rd_next;

  logic             tick;
  logic             step;
  logic             at_reload;
  logic             at_match;
  logic             cap_edge;
  logic             run;
  logic             pol;
  logic [DB_W-1:0]  db_delay;
  irq_t             events;
  irq_t             clear;

  ////////////////////////////////////////////////////////////
  // prescaler and deadband stages

  timer_prescaler u_prescaler (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .enable   (ctrl_reg.enable),
    .exponent (ctrl_reg.prescale_exponent),
    .tick     (tick)
  );

  // deadband only applies in dual pwm; elsewhere rise with no delay
  assign db_delay = (ctrl_reg.mode == MODE_PWM_DUAL) ?
                    ctrl0_reg.deadband_delay_field : DB_ZERO;

  timer_deadband u_db_out (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .level   (out_reg),
    .delay   (db_delay),
    .q       (timer_output_pin)
  );

  timer_deadband u_db_comp (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .level   (~out_reg),
    .delay   (db_delay),
    .q       (timer_output_comp)
  );

  ////////////////////////////////////////////////////////////
  // event decode

  assign run = ctrl_reg.enable;
  assign pol = ctrl_reg.output_polarity_bit;

  // capture edge follows polarity; comparator count always uses the rising edge
  assign cap_edge = pol ? (in_prev_reg && !timer_in)
                        : (!in_prev_reg && timer_in);

  // comparator counter counts input edges, all others the prescaler
  always_comb
  begin
    step = tick;
    if (ctrl_reg.mode == MODE_COMP_COUNT)
    begin
      step = run && !in_prev_reg && timer_in;
    end
  end

  assign at_reload = step && (count_reg == reload_reg);
  assign at_match  = run && (ctrl_reg.mode == MODE_PWM_DUAL) &&
                     step && (count_reg == pwm_reg);
  assign events.reload  = at_reload;
  assign events.capture = run && cap_edge &&
                          (ctrl_reg.mode == MODE_CAPTURE_RST);
  assign events.match   = at_match;

  ////////////////////////////////////////////////////////////
  // counter, capture and register writes
  // a bus write to the count wins over counting in the same cycle

  always_comb
  begin
    ctrl_next    = ctrl_reg;
    ctrl0_next   = ctrl0_reg;
    count_next   = count_reg;
    reload_next  = reload_reg;
    pwm_next     = pwm_reg;
    capture_next = capture_reg;
    mask_next    = mask_reg;
    clear        = IRQ_NONE;
    if (events.capture)
    begin
      capture_next = count_reg;
      count_next   = COUNT_RESTART;
    end
    else if (at_reload)
    begin
      count_next = COUNT_RESTART;
    end
    else if (step)
    begin
      count_next = count_reg + COUNT_RESTART;
    end
    if (wr_strobe)
    begin
      case (addr)
        ADDR_CTRL:       ctrl_next    = ctrl_t'(wr_data);
        ADDR_CTRL_ZERO:  ctrl0_next   = ctrl_zero_t'(wr_data & 8'h87);
        ADDR_COUNT_HI:   count_next   = set_byte(count_reg, 1'b1, wr_data);
        ADDR_COUNT_LO:   count_next   = set_byte(count_reg, 1'b0, wr_data);
        ADDR_RELOAD_HI:  reload_next  = set_byte(reload_reg, 1'b1, wr_data);
        ADDR_RELOAD_LO:  reload_next  = set_byte(reload_reg, 1'b0, wr_data);
        ADDR_PWM_HI:     pwm_next     = set_byte(pwm_reg, 1'b1, wr_data);
        ADDR_PWM_LO:     pwm_next     = set_byte(pwm_reg, 1'b0, wr_data);
        ADDR_IRQ_STATUS: clear        = irq_t'(wr_data[2:0]);
        ADDR_IRQ_MASK:   mask_next    = irq_t'(wr_data[2:0]);
        default:         clear        = IRQ_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // output level: follows polarity while stopped, moves only on
  // events while running, so a polarity write waits for a pwm event or the stop

  always_comb
  begin
    out_next = out_reg;
    if (!run)
    begin
      out_next = pol;
    end
    else
    begin
      case (ctrl_reg.mode)
        MODE_PWM_DUAL:
        begin
          if (at_reload)
          begin
            out_next = pol;
          end
          else if (at_match)
          begin
            out_next = !pol;
          end
        end
        MODE_CONTINUOUS, MODE_COMP_COUNT:
        begin
          if (at_reload)
          begin
            out_next = !out_reg;
          end
        end
        default:
        begin
          out_next = out_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // interrupt status: set wins over a write-one clear

  always_comb
  begin
    status_next = (status_reg & ~clear) | events;
    irq_next    = |(status_next & mask_next);
    pulse_next  = at_reload;
  end

  ////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero

  always_comb
  begin
    rd_next = DATA_ZERO;
    if (rd_strobe)
    begin
      case (addr)
        ADDR_CTRL:       rd_next = ctrl_reg;
        ADDR_CTRL_ZERO:  rd_next = ctrl0_reg;
        ADDR_COUNT_HI:   rd_next = byte_of(count_reg, 1'b1);
        ADDR_COUNT_LO:   rd_next = byte_of(count_reg, 1'b0);
        ADDR_RELOAD_HI:  rd_next = byte_of(reload_reg, 1'b1);
        ADDR_RELOAD_LO:  rd_next = byte_of(reload_reg, 1'b0);
        ADDR_PWM_HI:     rd_next = byte_of(pwm_reg, 1'b1);
        ADDR_PWM_LO:     rd_next = byte_of(pwm_reg, 1'b0);
        ADDR_CAPTURE_HI: rd_next = byte_of(capture_reg, 1'b1);
        ADDR_CAPTURE_LO: rd_next = byte_of(capture_reg, 1'b0);
        ADDR_IRQ_STATUS: rd_next = {5'h00, status_reg};
        ADDR_IRQ_MASK:   rd_next = {5'h00, mask_reg};
        default:         rd_next = DATA_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg    <= CTRL_RESET;
      ctrl0_reg   <= CTRL_ZERO_RESET;
      count_reg   <= COUNT_RESET;
      reload_reg  <= RELOAD_RESET;
      pwm_reg     <= PWM_RESET;
      capture_reg <= COUNT_RESET;
      status_reg  <= IRQ_NONE;
      mask_reg    <= IRQ_NONE;
      out_reg     <= 1'b0;
      in_prev_reg <= 1'b0;
      pulse_reg   <= 1'b0;
      irq_reg     <= 1'b0;
      oe_reg      <= 1'b0;
      rd_reg      <= DATA_ZERO;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      ctrl0_reg   <= ctrl0_next;
      count_reg   <= count_next;
      reload_reg  <= reload_next;
      pwm_reg     <= pwm_next;
      capture_reg <= capture_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      out_reg     <= out_next;
      in_prev_reg <= timer_in;
      pulse_reg   <= pulse_next;
      irq_reg     <= irq_next;
      oe_reg      <= ctrl0_next.alt_fn_en;
      rd_reg      <= rd_next;
    end
  end

  // pin drive ignores any data-direction setting outside the timer
  assign timer_pin_oe = oe_reg;
  assign reload_pulse = pulse_reg;
  assign irq          = irq_reg;
  assign rd_data      = rd_reg;

endmodule : timer_top

// [rtl/timer_pkg.sv]
// constants, register map and carrier types of the 16-bit timer
// assumes one 20 MHz system clock and an 8-bit register port
package timer_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 7;
  localparam int DB_W   = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL       = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ZERO  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HI   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LO   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_HI  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_LO  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_PWM_HI     = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_PWM_LO     = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_HI = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_LO = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'ha;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 4'hb;

  // reset values and fixed counts
  localparam logic [CNT_W-1:0]  COUNT_RESET    = 16'h0000;
  localparam logic [CNT_W-1:0]  COUNT_RESTART  = 16'h0001;
  localparam logic [CNT_W-1:0]  RELOAD_RESET   = 16'hffff;
  localparam logic [CNT_W-1:0]  PWM_RESET      = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO      = 8'h00;
  localparam logic [PRE_W-1:0]  PRE_ZERO       = 7'h00;
  localparam logic [DB_W-1:0]   DB_ZERO        = 3'h0;
  localparam logic [DB_W-1:0]   DB_ONE         = 3'h1;

  typedef enum logic [2:0] {
    MODE_CONTINUOUS  = 3'h0,
    MODE_PWM_DUAL    = 3'h1,
    MODE_CAPTURE_RST = 3'h2,
    MODE_COMP_COUNT  = 3'h3
  } mode_t;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic             enable;
    logic             output_polarity_bit;
    logic [2:0]       prescale_exponent;
    mode_t            mode;
  } ctrl_t;

  // second control register: alternate function and deadband
  typedef struct packed {
    logic             alt_fn_en;
    logic [3:0]       unused;
    logic [DB_W-1:0]  deadband_delay_field;
  } ctrl_zero_t;

  // interrupt status and mask layout
  typedef struct packed {
    logic             match;
    logic             capture;
    logic             reload;
  } irq_t;

  localparam ctrl_t      CTRL_RESET      = '{1'b0, 1'b0, 3'h0, MODE_CONTINUOUS};
  localparam ctrl_zero_t CTRL_ZERO_RESET = '{1'b0, 4'h0, 3'h0};
  localparam irq_t       IRQ_NONE        = '{1'b0, 1'b0, 1'b0};

  // low bits all ones for the divide-by-two-to-the-n terminal count
  function automatic logic [PRE_W-1:0] prescale_mask(input logic [2:0] e);
    logic [PRE_W:0] one;
    one = 8'h01 << e;
    return PRE_W'(one - 8'h01);
  endfunction : prescale_mask

  function automatic logic [DATA_W-1:0] byte_of(input logic [CNT_W-1:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction : byte_of

  function automatic logic [CNT_W-1:0] set_byte(input logic [CNT_W-1:0] v, input logic hi,
                                                input logic [DATA_W-1:0] b);
    return hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction : set_byte

endpackage : timer_pkg

// [rtl/timer_prescaler.sv]
// power-of-two prescaler giving one-cycle count ticks
// assumes enable comes from a register of the timer top
`timescale 1ns/100ps
module timer_prescaler
  import timer_pkg::*;
(
  input  wire logic       ref_clk,   // system clock
  input  wire logic       reset_n,   // async reset, active low
  input  wire logic       enable,    // timer enable
  input  wire logic [2:0] exponent,  // divide by two to this power
  output logic            tick       // one-cycle count tick
);

  logic [PRE_W-1:0] div_reg;
  logic [PRE_W-1:0] div_next;
  logic [PRE_W-1:0] mask;

  ////////////////////////////////////////////////////////////
  // held at zero while disabled so every restart divides cleanly
  always_comb
  begin
    mask     = prescale_mask(exponent);
    tick     = enable && (div_reg == mask);
    div_next = div_reg + 7'h01;
    if (!enable || tick)
    begin
      div_next = PRE_ZERO;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_reg <= PRE_ZERO;
    end
    else
    begin
      div_reg <= div_next;
    end
  end

endmodule : timer_prescaler

// [rtl/timer_deadband.sv]
// delays only the rising edge of one output by a few cycles
// assumes a level input from the timer output logic
`timescale 1ns/100ps
module timer_deadband
  import timer_pkg::*;
(
  input  wire logic            ref_clk,  // system clock
  input  wire logic            reset_n,  // async reset, active low
  input  wire logic            level,    // undelayed level
  input  wire logic [DB_W-1:0] delay,    // extra cycles on rising edge
  output logic                 q         // delayed level, registered
);

  logic [DB_W-1:0] wait_reg;
  logic [DB_W-1:0] wait_next;
  logic            q_next;

  ////////////////////////////////////////////////////////////
  // falling edges pass at once, rising edges wait out the delay
  always_comb
  begin
    wait_next = DB_ZERO;
    q_next    = 1'b0;
    if (level)
    begin
      if (q || wait_reg >= delay)
      begin
        q_next    = 1'b1;
        wait_next = wait_reg;
      end
      else
      begin
        wait_next = wait_reg + DB_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_reg <= DB_ZERO;
      q        <= 1'b0;
    end
    else
    begin
      wait_reg <= wait_next;
      q        <= q_next;
    end
  end

endmodule : timer_deadband

// [verification/timer_chk.sv]
// assertions on the ports of the timer top
// assumes the register map of timer_pkg and one clock domain
`timescale 1ns/100ps
module timer_chk
  import timer_pkg::*;
(
  input wire logic              ref_clk,           // clock
  input wire logic              reset_n,           // reset
  input wire logic [ADDR_W-1:0] addr,              // address
  input wire logic [DATA_W-1:0] wr_data,           // write data
  input wire logic              wr_strobe,         // write
  input wire logic              rd_strobe,         // read
  input wire logic [DATA_W-1:0] rd_data,           // read data
  input wire logic              timer_in,          // input
  input wire logic              timer_output_pin,  // output
  input wire logic              timer_pin_oe,      // pin enable
  input wire logic              timer_output_comp, // complement
  input wire logic              reload_pulse,      // reload
  input wire logic              irq                // interrupt
);
  ctrl_t      ctrl_m;   // control mirror
  irq_t       mask_m;   // mask mirror
  logic [3:0] idle_cnt; // settled cycles while disabled
  logic       w_ctrl;
  logic       w_zero;
  logic       run_cont;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  // write decode
  assign w_ctrl   = wr_strobe && (addr == ADDR_CTRL);
  assign w_zero   = wr_strobe && (addr == ADDR_CTRL_ZERO);
  assign run_cont = ctrl_m.enable && (ctrl_m.mode == MODE_CONTINUOUS);

  // mirrors; idle count restarts on config writes, a deadband may still run out
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_m   <= CTRL_RESET;
      mask_m   <= IRQ_NONE;
      idle_cnt <= 4'h0;
    end
    else
    begin
      if (w_ctrl)
        ctrl_m <= ctrl_t'(wr_data);
      if (wr_strobe && (addr == ADDR_IRQ_MASK))
        mask_m <= irq_t'(wr_data[2:0]);
      if (w_ctrl || w_zero || ctrl_m.enable)
        idle_cnt <= 4'h0;
      else if (idle_cnt != 4'hf)
        idle_cnt <= idle_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////
  // properties
  property p_no_overlap;
    !(timer_output_pin && timer_output_comp);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("output and complement both high");
  property p_idle_level;
    (idle_cnt == 4'hf) && (ctrl_m.mode <= MODE_COMP_COUNT)
      |-> (timer_output_pin == ctrl_m.output_polarity_bit) && (timer_output_comp != timer_output_pin);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level off");
  property p_oe_on;
    (w_zero && wr_data[7]) ##1 !w_zero [*2] |-> timer_pin_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  property p_pulse_one;
    reload_pulse |=> !reload_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reload pulse too long");
  property p_irq_reload;
    reload_pulse && mask_m.reload |-> ##[0:2] irq;
  endproperty
  a_irq_reload: assert property (p_irq_reload) else $error("no irq on reload");
  property p_cont_toggle;
    reload_pulse && run_cont |-> ##[1:2] $changed(timer_output_pin);
  endproperty
  a_cont_toggle: assert property (p_cont_toggle) else $error("no toggle on reload");
  property p_pol_hold;
    (w_ctrl && run_cont && wr_data[7] && (wr_data[2:0] == 3'h0) && !reload_pulse) ##1 !reload_pulse [*2]
      |=> timer_output_pin == $past(timer_output_pin, 3);
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("pin moved on polarity write");
  property p_cap_irq;
    (ctrl_m.enable && (ctrl_m.mode == MODE_CAPTURE_RST) && mask_m.capture
      && (ctrl_m.output_polarity_bit ? $fell(timer_in) : $rose(timer_in))) |-> ##[1:5] irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("no capture irq");
  c_reload: cover property (reload_pulse && run_cont);
  c_pwm_gap: cover property (ctrl_m.enable && !timer_output_pin && !timer_output_comp);
  c_irq: cover property ($rose(irq));
endmodule : timer_chk

bind timer_top timer_chk i_chk (.ref_clk, .reset_n, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data,
  .timer_in, .timer_output_pin, .timer_pin_oe, .timer_output_comp, .reload_pulse, .irq);

// [verification/timer_mode_polarity_prescale_bench.sv]
// self-checking bench of the timer top
// assumes the timer_pkg register map; the bench drives every port itself
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fail_count++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module timer_mode_polarity_prescale_bench
  import timer_pkg::*;
;
  logic              ref_clk = 1'b0;   // 50 ns clock
  logic              reset_n = 1'b0;   // async reset
  logic [ADDR_W-1:0] addr = 4'h0;      // address
  logic [DATA_W-1:0] wr_data = 8'h00;  // write data
  logic              wr_strobe = 1'b0; // write
  logic              rd_strobe = 1'b0; // read
  logic              timer_in = 1'b0;  // timer input
  logic [DATA_W-1:0] rd_data;
  logic              timer_output_pin;
  logic              timer_pin_oe;
  logic              timer_output_comp;
  logic              reload_pulse;
  logic              irq;
  logic              lvl;
  logic              pol;
  logic [2:0]        db;
  int                fail_count = 0;
  int                tests_run = 0;
  int                t0, t1, na, nc;

  timer_top i_dut (.ref_clk, .reset_n, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .timer_in,
    .timer_output_pin, .timer_pin_oe, .timer_output_comp, .reload_pulse, .irq);

  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////
  // bus tasks; two cycles each so a strobe is never set and cleared in one step
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    tick(1);
    wr_strobe <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string n);
    addr <= a;
    rd_strobe <= 1'b1;
    tick(1);
    rd_strobe <= 1'b0;
    tick(1);
    `CHK(n, e, rd_data)
  endtask : rd
  // cycles up to the next reload pulse, bounded
  task automatic wait_pulse(output int t);
    t = 0;
    do
    begin
      tick(1);
      t++;
    end
    while (reload_pulse !== 1'b1 && t < 2000);
    `CHK("reload pulse", 1'b1, reload_pulse)
  endtask : wait_pulse
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    tick(2);
    reset_n <= 1'b1;
    tick(3);
    `CHK("comp", 1'b1, timer_output_comp)
    `CHK("oe", 1'b0, timer_pin_oe)
    rd(ADDR_RELOAD_HI, 8'hff, "reload hi");
    rd(ADDR_CTRL, 8'h00, "ctrl");
    wr(4'hc, 8'h5a);
    rd(4'hc, 8'h00, "unmapped");
    // continuous, reload 3, every prescale; offset must not depend on old prescaler state
    wr(ADDR_RELOAD_HI, 8'h00);
    wr(ADDR_RELOAD_LO, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_CTRL_ZERO, 8'h80);
    for (int p = 0; p < 8; p++)
    begin
      wr(ADDR_COUNT_LO, 8'h01);
      wr(ADDR_CTRL, {2'b10, p[2:0], 3'h0});
      wait_pulse(t0);
      wait_pulse(t1);
      // a cleared prescaler makes the first period after enable a full one
      `CHK("period", 3 << p, t1)
      `CHK("offset", 0, t0 - t1)
      wr(ADDR_CTRL, 8'h00);
    end
    tick(1);
    `CHK("irq set", 1'b1, irq)
    wr(ADDR_IRQ_MASK, 8'h00);
    tick(1);
    `CHK("irq masked", 1'b0, irq)
    rd(ADDR_IRQ_STATUS, 8'h01, "status");
    wr(ADDR_IRQ_STATUS, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h00, "cleared");
    // dual pwm: duty of output and complement over one period
    wr(ADDR_RELOAD_LO, 8'h10);
    wr(ADDR_PWM_LO, 8'h08);
    for (int k = 0; k < 3; k++)
    begin
      pol = (k == 2);
      db = (k == 1) ? 3'h3 : 3'h0;
      wr(ADDR_CTRL_ZERO, {5'h10, db});
      wr(ADDR_CTRL, {1'b1, pol, 6'h01});
      wait_pulse(t0);
      na = 0;
      nc = 0;
      do
      begin
        tick(1);
        na += int'(timer_output_pin !== pol);
        nc += int'(timer_output_comp === pol);
      end
      while (reload_pulse !== 1'b1);
      `CHK("pwm out", 8 - db, na)
      `CHK("pwm comp", 8 + db, nc)
      wr(ADDR_CTRL, {1'b0, pol, 6'h01});
      tick(12);
      `CHK("pwm idle", pol, timer_output_pin)
    end
    // capture restart: only the edge chosen by polarity is captured
    wr(ADDR_PWM_LO, 8'hff);
    wr(ADDR_RELOAD_LO, 8'hff);
    wr(ADDR_IRQ_MASK, 8'h02);
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_CTRL, {1'b1, k[0], 6'h02});
      wr(ADDR_IRQ_STATUS, 8'h07);
      timer_in <= 1'b1;
      tick(4);
      rd(ADDR_IRQ_STATUS, k ? 8'h00 : 8'h02, "rise capture");
      wr(ADDR_IRQ_STATUS, 8'h07);
      timer_in <= 1'b0;
      tick(4);
      rd(ADDR_IRQ_STATUS, k ? 8'h02 : 8'h00, "fall capture");
    end
    // comparator counter, polarity one, reload after two input edges
    wr(ADDR_CTRL, 8'h43);
    wr(ADDR_RELOAD_LO, 8'h02);
    wr(ADDR_COUNT_LO, 8'h01);
    tick(12);
    `CHK("cc idle", 1'b1, timer_output_pin)
    `CHK("oe on", 1'b1, timer_pin_oe)
    wr(ADDR_CTRL, 8'hc3);
    repeat (2)
    begin
      timer_in <= 1'b1;
      tick(3);
      timer_in <= 1'b0;
      tick(3);
    end
    `CHK("cc toggle", 1'b0, timer_output_pin)
    // polarity flipped while running must not move the pin
    wr(ADDR_RELOAD_LO, 8'hff);
    wr(ADDR_CTRL, 8'h80);
    tick(4);
    lvl = timer_output_pin;
    wr(ADDR_CTRL, 8'hc0);
    tick(2);
    `CHK("pol hold", lvl, timer_output_pin)
    wr(ADDR_CTRL, 8'h40);
    tick(12);
    `CHK("pol idle", 1'b1, timer_output_pin)
    stop_test();
  end

  // watchdog; the whole sequence needs far fewer cycles than this
  initial
  begin
    tick(20000);
    fail_count++;
    stop_test();
  end
endmodule : timer_mode_polarity_prescale_bench
